// File: rtl/asr_pkg.sv
// Package for the ADC status, averaging and offset register group
package asr_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [6:0] ADDR_FAULT_FLAGS = 7'h11;
  localparam logic [6:0] ADDR_LEAVE_SETUP = 7'h14;
  localparam logic [6:0] ADDR_AVERAGING = 7'h15;
  localparam logic [6:0] ADDR_CH0_OFS_LOW = 7'h17;
  localparam logic [6:0] ADDR_CH0_OFS_HIGH = 7'h18;
  localparam logic [6:0] ADDR_CH1_OFS_LOW = 7'h1a;
  localparam logic [6:0] ADDR_CH1_OFS_HIGH = 7'h1b;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int CLK_FAULT_BIT = 4;
  localparam int LEAVE_BIT = 0;
  localparam int RESTART_BIT = 7;
  localparam int EXP_MSB = 4;
  localparam int EXP_WIDTH = 5;
  localparam logic [4:0] EXP_MAX_VALID = 5'h10;
  localparam logic [4:0] EXP_NONE = 5'h00;
  localparam logic [2:0] FORMAT_AVERAGED = 3'h3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int OFFSET_WIDTH = 16;
  localparam int OFFSET_STEP_EXP = 15;
  localparam int GAIN_UNITY = 32768;
  // ----------------------------------------
  // Serial frame
  // ----------------------------------------
  localparam logic [5:0] FRAME_BITS = 6'd16;
  localparam int FRAME_CNT_WIDTH = 6;
endpackage : asr_pkg

// File: rtl/asr_frame_counter.sv
// Counts serial clock edges of one transaction and flags a wrong count
`timescale 1ns/1ns
module asr_frame_counter #(
  parameter logic [5:0] EXPECTED = 6'd16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic frameActive,
  input wire logic bitStrobe,
  output logic countFault
);
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic act_reg;
  logic act_next;
  logic fault_next;

  always_comb begin
    act_next = frameActive;
    fault_next = 1'b0;
    cnt_next = cnt_reg;
    if (frameActive && !act_reg) begin
      cnt_next = bitStrobe ? 6'd1 : 6'd0;
    end else if (frameActive && bitStrobe && cnt_reg != 6'h3f) begin
      cnt_next = cnt_reg + 6'd1;
    end
    // Frame end: any count other than exactly one or two whole words is a fault
    if (!frameActive && act_reg) begin
      fault_next = (cnt_reg == 6'd0) || (cnt_reg != EXPECTED && cnt_reg != (EXPECTED << 1));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_reg <= 6'h00;
      act_reg <= 1'b0;
      countFault <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
      countFault <= fault_next;
    end
  end
endmodule : asr_frame_counter

// File: rtl/asr_regs.sv
// Status, leave-setup, averaging and offset registers on a byte register port
`timescale 1ns/1ns
module asr_regs (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic chipSelectN,
  input wire logic serialClockEdge,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic [2:0] outputFormatSelect,
  output logic [7:0] regReadData,
  output logic configMode,
  output logic filterRestart,
  output logic [4:0] filterLengthExponent,
  output logic [16:0] filterBlockLength,
  output logic averagingActive,
  output logic settingInvalid,
  output logic [15:0] firstChannelOffsetWord,
  output logic [15:0] secondChannelOffsetWord
);
  // ----------------------------------------
  // Transaction clock tally
  // ----------------------------------------
  logic countFault;

  asr_frame_counter #(
    .EXPECTED(asr_pkg::FRAME_BITS)
  ) u_counter (
    .ref_clk(ref_clk),
    .reset(reset),
    .frameActive(!chipSelectN),
    .bitStrobe(serialClockEdge),
    .countFault(countFault)
  );

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic clkFault_reg;
  logic clkFault_next;
  logic leave_reg;
  logic leave_next;
  logic config_reg;
  logic config_next;
  logic restart_reg;
  logic restart_next;
  logic [4:0] exp_reg;
  logic [4:0] exp_next;
  logic [15:0] ofs0_reg;
  logic [15:0] ofs0_next;
  logic [15:0] ofs1_reg;
  logic [15:0] ofs1_next;
  logic [7:0] rd_reg;
  logic [7:0] rd_next;
  logic [16:0] blk_reg;
  logic [16:0] blk_next;
  logic avg_reg;
  logic avg_next;
  logic inval_reg;
  logic inval_next;
  logic csHigh_reg;

  always_comb begin
    clkFault_next = clkFault_reg;
    leave_next = leave_reg;
    config_next = config_reg;
    restart_next = 1'b0;
    exp_next = exp_reg;
    ofs0_next = ofs0_reg;
    ofs1_next = ofs1_reg;
    rd_next = rd_reg;
    if (regWrite) begin
      unique case (regAddr)
        asr_pkg::ADDR_FAULT_FLAGS: begin
          if (regWriteData[asr_pkg::CLK_FAULT_BIT]) begin
            clkFault_next = 1'b0;
          end
        end
        asr_pkg::ADDR_LEAVE_SETUP: begin
          leave_next = regWriteData[asr_pkg::LEAVE_BIT];
          if (regWriteData[asr_pkg::LEAVE_BIT]) begin
            config_next = 1'b0;
          end
        end
        asr_pkg::ADDR_AVERAGING: begin
          restart_next = regWriteData[asr_pkg::RESTART_BIT];
          exp_next = regWriteData[asr_pkg::EXP_MSB:0];
        end
        asr_pkg::ADDR_CH0_OFS_LOW: ofs0_next[7:0] = regWriteData;
        asr_pkg::ADDR_CH0_OFS_HIGH: ofs0_next[15:8] = regWriteData;
        asr_pkg::ADDR_CH1_OFS_LOW: ofs1_next[7:0] = regWriteData;
        asr_pkg::ADDR_CH1_OFS_HIGH: ofs1_next[15:8] = regWriteData;
        default: begin
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    if (countFault) begin
      clkFault_next = 1'b1;
    end
    if (chipSelectN && !csHigh_reg) begin
      leave_next = 1'b0;
    end
    if (regRead) begin
      unique case (regAddr)
        asr_pkg::ADDR_FAULT_FLAGS: rd_next = {3'h0, clkFault_reg, 4'h0};
        asr_pkg::ADDR_LEAVE_SETUP: rd_next = {7'h00, leave_reg};
        asr_pkg::ADDR_AVERAGING: rd_next = {restart_reg, 2'h0, exp_reg};
        asr_pkg::ADDR_CH0_OFS_LOW: rd_next = ofs0_reg[7:0];
        asr_pkg::ADDR_CH0_OFS_HIGH: rd_next = ofs0_reg[15:8];
        asr_pkg::ADDR_CH1_OFS_LOW: rd_next = ofs1_reg[7:0];
        asr_pkg::ADDR_CH1_OFS_HIGH: rd_next = ofs1_reg[15:8];
        default: rd_next = asr_pkg::RESET_BYTE;
      endcase
    end
    // Block length 2^N; invalid codes give zero rather than wrapping
    blk_next = (exp_next <= asr_pkg::EXP_MAX_VALID) ? (17'h00001 << exp_next) : 17'h00000;
    avg_next = (outputFormatSelect == asr_pkg::FORMAT_AVERAGED);
    // Host-side misuse is reported, not corrected
    inval_next = (exp_next > asr_pkg::EXP_MAX_VALID)
        || (avg_next && exp_next == asr_pkg::EXP_NONE);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clkFault_reg <= 1'b0;
      leave_reg <= 1'b0;
      config_reg <= 1'b1;
      restart_reg <= 1'b0;
      exp_reg <= 5'h00;
      ofs0_reg <= 16'h0000;
      ofs1_reg <= 16'h0000;
      rd_reg <= 8'h00;
      blk_reg <= 17'h00001;
      avg_reg <= 1'b0;
      inval_reg <= 1'b0;
      csHigh_reg <= 1'b1;
    end else begin
      clkFault_reg <= clkFault_next;
      leave_reg <= leave_next;
      config_reg <= config_next;
      restart_reg <= restart_next;
      exp_reg <= exp_next;
      ofs0_reg <= ofs0_next;
      ofs1_reg <= ofs1_next;
      rd_reg <= rd_next;
      blk_reg <= blk_next;
      avg_reg <= avg_next;
      inval_reg <= inval_next;
      csHigh_reg <= chipSelectN;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Offset step and gain scaling belong to the datapath that reads these words
  assign regReadData = rd_reg;
  assign configMode = config_reg;
  assign filterRestart = restart_reg;
  assign filterLengthExponent = exp_reg;
  assign filterBlockLength = blk_reg;
  assign averagingActive = avg_reg;
  assign settingInvalid = inval_reg;
  assign firstChannelOffsetWord = ofs0_reg;
  assign secondChannelOffsetWord = ofs1_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  fault_set_a: assert property (@(posedge ref_clk) disable iff (reset)
    countFault |=> clkFault_reg) else $error("Clock fault not latched");
  fault_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    regWrite && regAddr == 7'h11 && regWriteData[4] && !countFault |=> !clkFault_reg)
    else $error("Fault flag not cleared");
  fault_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
    clkFault_reg && !(regWrite && regAddr == 7'h11 && regWriteData[4]) |=> clkFault_reg)
    else $error("Fault flag lost");
  leave_mode_a: assert property (@(posedge ref_clk) disable iff (reset)
    regWrite && regAddr == 7'h14 && regWriteData[0] |=> !configMode)
    else $error("Config mode not left");
  leave_self_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(chipSelectN) |=> !leave_reg) else $error("Leave bit not self cleared");
  restart_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
    filterRestart |=> !filterRestart || $past(regWrite)) else $error("Restart stuck");
  block_len_a: assert property (@(posedge ref_clk) disable iff (reset)
    exp_reg == 5'h10 |-> blk_reg == 17'h10000) else $error("Block length wrong");
  ofs_high_a: assert property (@(posedge ref_clk) disable iff (reset)
    regWrite && regAddr == 7'h18 |=> ofs0_reg[15:8] == $past(regWriteData))
    else $error("Offset high byte not stored");
  ofs1_low_a: assert property (@(posedge ref_clk) disable iff (reset)
    regWrite && regAddr == 7'h1a |=> ofs1_reg[7:0] == $past(regWriteData))
    else $error("Offset low byte not stored");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
    regRead && regAddr == 7'h11 |=> regReadData[7:5] == 3'h0 && regReadData[3:0] == 4'h0)
    else $error("Reserved bits not zero");
  zero_exp_a: assert property (@(posedge ref_clk) disable iff (reset)
    averagingActive && filterLengthExponent == asr_pkg::EXP_NONE |-> settingInvalid)
    else $error("Zero exponent under averaging not flagged");
  bad_code_a: assert property (@(posedge ref_clk) disable iff (reset)
    filterLengthExponent > asr_pkg::EXP_MAX_VALID |-> settingInvalid && blk_reg == 17'h00000)
    else $error("Invalid exponent code not flagged");
  format_track_a: assert property (@(posedge ref_clk) disable iff (reset)
    outputFormatSelect == asr_pkg::FORMAT_AVERAGED |=> averagingActive)
    else $error("Averaged format not followed");
  format_plain_a: assert property (@(posedge ref_clk) disable iff (reset)
    outputFormatSelect != asr_pkg::FORMAT_AVERAGED |=> !averagingActive)
    else $error("Plain format not followed");
  fault_seen_c: cover property (@(posedge ref_clk) disable iff (reset) $rose(clkFault_reg));
  leave_seen_c: cover property (@(posedge ref_clk) disable iff (reset) $fell(configMode));
  restart_seen_c: cover property (@(posedge ref_clk) disable iff (reset) filterRestart);
  invalid_seen_c: cover property (@(posedge ref_clk) disable iff (reset) settingInvalid);
endmodule : asr_regs

// File: verification/asr_host_model.sv
// Host model: register port accesses and serial frames
`timescale 1ns/1ns
module asr_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] regReadData,
  output logic chipSelectN,
  output logic serialClockEdge,
  output logic regWrite,
  output logic regRead,
  output logic [6:0] regAddr,
  output logic [7:0] regWriteData
);
  initial begin
    chipSelectN = 1'b1;
    serialClockEdge = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 7'h00;
    regWriteData = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    @(posedge ref_clk) #1;
    regWrite = 1'b0;
    // Released byte lane must not keep showing the old value
    regWriteData = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge ref_clk) #1;
    regAddr = a;
    regRead = 1'b1;
    @(posedge ref_clk) #1;
    regRead = 1'b0;
    d = regReadData;
  endtask : rd
  task automatic csSet(input logic v);
    @(posedge ref_clk) #1;
    chipSelectN = v;
  endtask : csSet
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge ref_clk) #1;
      serialClockEdge = 1'b1;
      @(posedge ref_clk) #1;
      serialClockEdge = 1'b0;
    end
  endtask : edges
endmodule : asr_host_model

// File: verification/adc_status_avg_offset_regs_tb.sv
// Self-checking bench for the status, averaging and offset registers
`timescale 1ns/1ns
module adc_status_avg_offset_regs_tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic chipSelectN, serialClockEdge, regWrite, regRead;
  logic [6:0] regAddr;
  logic [7:0] regWriteData, regReadData, rdData, e;
  logic [2:0] outputFormatSelect = 3'h3;
  logic configMode, filterRestart, averagingActive, settingInvalid;
  logic [4:0] filterLengthExponent;
  logic [16:0] filterBlockLength;
  logic [15:0] firstChannelOffsetWord, secondChannelOffsetWord, ofs;
  logic [6:0] addrs[7] = '{7'h11, 7'h14, 7'h15, 7'h17, 7'h18, 7'h1a, 7'h1b};
  int lens[5] = '{16, 5, 32, 33, 0};
  int n_errors = 0;
  int total_checks = 0;
  int seed = 69;
  int n;
  always #4 ref_clk = ~ref_clk;
  asr_host_model host (.ref_clk(ref_clk), .regReadData(regReadData),
    .chipSelectN(chipSelectN), .serialClockEdge(serialClockEdge), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData));
  asr_regs DUT (.ref_clk(ref_clk), .reset(reset), .chipSelectN(chipSelectN),
    .serialClockEdge(serialClockEdge), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWriteData(regWriteData),
    .outputFormatSelect(outputFormatSelect), .regReadData(regReadData),
    .configMode(configMode), .filterRestart(filterRestart),
    .filterLengthExponent(filterLengthExponent), .filterBlockLength(filterBlockLength),
    .averagingActive(averagingActive), .settingInvalid(settingInvalid),
    .firstChannelOffsetWord(firstChannelOffsetWord),
    .secondChannelOffsetWord(secondChannelOffsetWord));
  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rdChk(input logic [6:0] a, input logic [7:0] x, input string m);
    host.rd(a, rdData);
    chk(17'(rdData), 17'(x), m);
  endtask : rdChk
  function automatic logic [16:0] blockLen(input int x);
    return 17'h00001 << x;
  endfunction : blockLen
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // Whole run needs well under 2000 cycles
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 reset = 1'b0;
    foreach (addrs[i]) rdChk(addrs[i], 8'h00, "reset value");
    chk(17'(configMode), 17'h1, "config mode after reset");
    host.wr(7'h12, 8'hff);
    rdChk(7'h12, 8'h00, "unmapped read");
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      ofs = c[1] ? 16'h8000 : 16'($random(seed));
      host.wr(c[0] ? 7'h1a : 7'h17, ofs[7:0]);
      host.wr(c[0] ? 7'h1b : 7'h18, ofs[15:8]);
      rdChk(c[0] ? 7'h1a : 7'h17, ofs[7:0], "offset low");
      rdChk(c[0] ? 7'h1b : 7'h18, ofs[15:8], "offset high");
      chk(17'(c[0] ? secondChannelOffsetWord : firstChannelOffsetWord), 17'(ofs),
        "offset word");
    end
    $display("test offsets done");
    for (int i = 1; i <= 20; i++) begin
      n = (i <= 16) ? i : 1 + int'($unsigned($random(seed)) % 16);
      host.wr(7'h15, 8'h60 | 8'(n));
      rdChk(7'h15, 8'(n), "exponent readback");
      chk(filterBlockLength, blockLen(n), "block length");
      chk(17'({averagingActive, settingInvalid}), 17'h2, "averaged setting");
    end
    host.wr(7'h15, 8'h85);
    chk(17'(filterRestart), 17'h1, "restart pulse");
    @(posedge ref_clk) #1;
    chk(17'(filterRestart), 17'h0, "restart pulse ends");
    rdChk(7'h15, 8'h05, "restart bit self clears");
    chk(filterBlockLength, 17'h00020, "block length of five");
    @(posedge ref_clk) #1 outputFormatSelect = 3'h0;
    host.wr(7'h15, 8'h00);
    chk(17'({averagingActive, settingInvalid}), 17'h0, "plain format");
    chk(filterBlockLength, 17'h00001, "block length of zero code");
    host.wr(7'h15, 8'h10);
    @(posedge ref_clk) #1 outputFormatSelect = 3'h3;
    @(posedge ref_clk) #1;
    chk(17'({averagingActive, settingInvalid}), 17'h2, "averaged format again");
    chk(filterBlockLength, 17'h10000, "block length of top code");
    $display("test averaging done");
    host.csSet(1'b0);
    host.wr(7'h14, 8'hff);
    rdChk(7'h14, 8'h01, "leave bit set");
    chk(17'(configMode), 17'h0, "config mode left");
    host.csSet(1'b1);
    repeat (2) @(posedge ref_clk);
    rdChk(7'h14, 8'h00, "leave bit cleared");
    host.wr(7'h11, 8'h10);
    $display("test leave setup done");
    lens[4] = 1 + int'($unsigned($random(seed)) % 15);
    foreach (lens[i]) begin
      host.csSet(1'b0);
      host.edges(lens[i]);
      host.csSet(1'b1);
      repeat (3) @(posedge ref_clk);
      e = (lens[i] == 16 || lens[i] == 32) ? 8'h00 : 8'h10;
      rdChk(7'h11, e, "clock fault flag");
      host.wr(7'h11, 8'hef);
      rdChk(7'h11, e, "zero write keeps flag");
      host.wr(7'h11, 8'h10);
      rdChk(7'h11, 8'h00, "one write clears flag");
    end
    $display("test clock fault done");
    report_and_stop();
  end
endmodule : adc_status_avg_offset_regs_tb
